// >>> design/hss_top.sv
// histogram scan sequencer with axi4-lite command and status registers
module hss_top (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // measurement front end
    output logic             meas_req,
    output logic [1:0]       meas_kind,
    output logic [7:0]       meas_mass,
    output logic             meas_use_mult,
    output logic [2:0]       meas_noise_floor,
    input  wire logic        meas_done,
    input  wire logic [31:0] meas_value,
    // byte stream to the serial transmitter
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready
);
    hss_pkg::hss_state_t st_q, st_d;

    logic                aw_rdy_q, w_rdy_q, aw_ok_q, w_ok_q, bv_q, ar_rdy_q, rv_q;
    logic [1:0]          bresp_q;
    logic [7:0]          waddr_q;
    logic [31:0]         wdata_q, rdata_q;
    logic [3:0]          wstrb_q;
    logic [7:0]          init_q, final_q, mass_q;
    logic [2:0]          nf_q, run_nf_q;
    logic                mult_q, run_mult_q, cont_q;
    logic [15:0]         scans_q;
    logic [8:0]          pts_q;
    logic [31:0]         zero_q;
    logic [15:0]         tmr_q;
    logic                req_q;
    logic [1:0]          kind_q;
    logic [31:0]         buf_mem [0:(1 << hss_pkg::BUF_AW) - 1];
    logic [hss_pkg::BUF_AW:0] wr_q, rd_q;
    logic                txv_q;
    logic [7:0]          txd_q;
    logic [23:0]         sh_q;
    logic [1:0]          bidx_q;

    // axi handshakes: one write and one read in flight, aw and w in any order
    wire        aw_fire = s_axi_awvalid & aw_rdy_q;
    wire        w_fire  = s_axi_wvalid & w_rdy_q;
    wire        wr_go   = aw_ok_q & w_ok_q & ~bv_q;
    wire        aw_ok_n = (aw_ok_q | aw_fire) & ~wr_go;
    wire        w_ok_n  = (w_ok_q | w_fire) & ~wr_go;
    wire        bv_n    = wr_go | (bv_q & ~s_axi_bready);
    wire        ar_fire = s_axi_arvalid & ar_rdy_q;
    wire        rv_n    = ar_fire | (rv_q & ~s_axi_rready);

    // command decode; a command is any write of the low lane of the command word
    wire        wr_cmd  = wr_go & (waddr_q == hss_pkg::CMD_OFS) & wstrb_q[0];
    wire [7:0]  op      = wdata_q[hss_pkg::CODE_LSB +: 8];
    wire [15:0] arg     = wdata_q[hss_pkg::ARG_LSB +: 16];
    wire        is_trig = wr_cmd & (op == hss_pkg::OP_HIST_TRIG);
    wire        abort   = wr_cmd & (st_q != hss_pkg::ST_IDLE);

    // buffer and stream status
    // declared ahead of the status word, which reports pending data
    // pending counts the byte on offer too, so a drain never cuts a word short
    wire        buf_empty = (wr_q == rd_q);
    wire        pending   = ~buf_empty | txv_q;
    wire        tx_take   = txv_q & tx_ready;
    // no load on an abort edge: the flush must win over a fresh word
    wire        tx_load   = ~txv_q & ~buf_empty & ~abort;
    // head read is combinational; the serialiser copies it on load
    wire [31:0] head_word = buf_mem[rd_q[hss_pkg::BUF_AW-1:0]];

    // read decode
    // unmapped offsets answer with an error and a zero word
    wire        rd_hit  = (s_axi_araddr == hss_pkg::STATUS_OFS) | (s_axi_araddr == hss_pkg::POINTS_OFS)
                        | (s_axi_araddr == hss_pkg::SETTINGS_OFS) | (s_axi_araddr == hss_pkg::ZERO_OFS);
    wire [31:0] st_word = {scans_q, 8'h00, 2'h0, cont_q, run_mult_q, pending, st_q};
    wire [31:0] set_word = {4'h0, nf_q, mult_q, 8'h00, final_q, init_q};
    wire [31:0] rd_mux  = (s_axi_araddr == hss_pkg::STATUS_OFS)   ? st_word :
                          (s_axi_araddr == hss_pkg::POINTS_OFS)   ? {23'h0, pts_q} :
                          (s_axi_araddr == hss_pkg::SETTINGS_OFS) ? set_word :
                          (s_axi_araddr == hss_pkg::ZERO_OFS)     ? zero_q : 32'h0000_0000;

    // points count, zero when the range is inverted
    // masses are eight bits, so the count needs nine to hold 256
    wire [8:0]  span      = (final_q >= init_q) ? 9'({1'b0, final_q} - {1'b0, init_q} + 9'h001) : 9'h000;
    wire        last_mass = (mass_q == final_q);
    wire [15:0] dwell     = 16'((hss_pkg::NF_LEVELS - int'(run_nf_q)) * hss_pkg::DWELL_CYC);

    // buffer writes: corrected mass value, corrected total, or zero total
    wire [31:0] corr    = meas_value - zero_q;
    wire        wr_mass = (st_q == hss_pkg::ST_MEAS) & meas_done & ~abort;
    wire        wr_tot  = (st_q == hss_pkg::ST_TOTAL) & ~abort & (run_mult_q | meas_done);
    wire        wr_en   = wr_mass | wr_tot;
    wire [31:0] wr_val  = (wr_tot & run_mult_q) ? 32'h0000_0000 : corr;

    // sequencer next state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            hss_pkg::ST_IDLE:   if (is_trig) st_d = hss_pkg::ST_DRAIN;
            hss_pkg::ST_DRAIN:  if (~pending) st_d = hss_pkg::ST_ZERO;
            hss_pkg::ST_ZERO:   if (meas_done) st_d = hss_pkg::ST_CAL;
            hss_pkg::ST_CAL:    if (tmr_q == 16'h0000) st_d = hss_pkg::ST_SETTLE;
            hss_pkg::ST_SETTLE: if (tmr_q == 16'h0000) st_d = hss_pkg::ST_MEAS;
            hss_pkg::ST_MEAS:   if (meas_done) st_d = last_mass ? hss_pkg::ST_TOTAL : hss_pkg::ST_SETTLE;
            hss_pkg::ST_TOTAL:  if (wr_tot) st_d = hss_pkg::ST_DONE;
            hss_pkg::ST_DONE:   st_d = (cont_q | scans_q > 16'h0001) ? hss_pkg::ST_DRAIN : hss_pkg::ST_IDLE;
        endcase
        // an interrupting trigger restarts, anything else leaves the sequencer idle
        if (abort)
            st_d = is_trig ? hss_pkg::ST_DRAIN : hss_pkg::ST_IDLE;
    end

    // a request goes out on entry to zero and to each mass, and to total only with the multiplier off
    // entry-only pulses keep meas_req one cycle wide however long the answer takes
    wire enter   = (st_d != st_q);
    wire req_n   = enter & ((st_d == hss_pkg::ST_ZERO) | (st_d == hss_pkg::ST_MEAS)
                 | ((st_d == hss_pkg::ST_TOTAL) & ~run_mult_q));
    wire [1:0] kind_n = (st_d == hss_pkg::ST_ZERO) ? hss_pkg::KIND_ZERO :
                        (st_d == hss_pkg::ST_TOTAL) ? hss_pkg::KIND_TOTAL : hss_pkg::KIND_MASS;

    // axi write channel flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_ok_q  <= 1'b0;
            w_ok_q   <= 1'b0;
            aw_rdy_q <= 1'b0;
            w_rdy_q  <= 1'b0;
            bv_q     <= 1'b0;
        end else begin
            aw_ok_q  <= aw_ok_n;
            w_ok_q   <= w_ok_n;
            aw_rdy_q <= ~aw_ok_n & ~bv_n;
            w_rdy_q  <= ~w_ok_n & ~bv_n;
            bv_q     <= bv_n;
        end
    end

    // captured write payload and response; only the command word is writable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= hss_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) waddr_q <= s_axi_awaddr;
            if (w_fire) wdata_q <= s_axi_wdata;
            if (w_fire) wstrb_q <= s_axi_wstrb;
            if (wr_go) bresp_q <= (waddr_q == hss_pkg::CMD_OFS) ? hss_pkg::RESP_OKAY : hss_pkg::RESP_SLVERR;
        end
    end

    // axi read channel: data one cycle after the address is taken
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ar_rdy_q <= 1'b0;
            rv_q     <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            ar_rdy_q <= ~rv_n;
            rv_q     <= rv_n;
            if (ar_fire) rdata_q <= rd_mux;
        end
    end
    logic [1:0] rresp_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rresp_q <= hss_pkg::RESP_OKAY;
        else if (ar_fire) rresp_q <= rd_hit ? hss_pkg::RESP_OKAY : hss_pkg::RESP_SLVERR;
    end

    // settings: shared mass range, noise floor, detector choice
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_q  <= hss_pkg::INIT_MASS_RST;
            final_q <= hss_pkg::FINAL_MASS_RST;
            nf_q    <= hss_pkg::NF_RST;
            mult_q  <= 1'b0;
        end else if (wr_cmd) begin
            if (op == hss_pkg::OP_INIT_MASS) init_q <= arg[7:0];
            if (op == hss_pkg::OP_FINAL_MASS) final_q <= arg[7:0];
            if (op == hss_pkg::OP_NOISE_FLOOR) nf_q <= arg[2:0];
            if (op == hss_pkg::OP_MULT_VOLT) mult_q <= (arg != 16'h0000);
        end
    end

    // points query reply
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) pts_q <= 9'h000;
        else if (wr_cmd & (op == hss_pkg::OP_HIST_POINTS)) pts_q <= span;
    end

    // trigger-time snapshot; host settings after this do not reach the running scan
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_mult_q <= 1'b0;
            run_nf_q   <= hss_pkg::NF_RST;
            cont_q     <= 1'b0;
            scans_q    <= 16'h0000;
        end else if (is_trig) begin
            run_mult_q <= mult_q;
            run_nf_q   <= nf_q;
            cont_q     <= (arg == 16'h0000);
            scans_q    <= arg;
        end else if (abort) begin
            cont_q     <= 1'b0;
            scans_q    <= 16'h0000;
        end else if (st_q == hss_pkg::ST_DONE && !cont_q && scans_q != 16'h0000) begin
            scans_q    <= scans_q - 16'h0001;
        end
    end

    // state, zero offset, mass stepping and delay timer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= hss_pkg::ST_IDLE;
            zero_q <= hss_pkg::ZERO_RST;
            mass_q <= 8'h00;
            tmr_q  <= 16'h0000;
        end else begin
            st_q <= st_d;
            if (st_q == hss_pkg::ST_ZERO && meas_done && !abort) zero_q <= meas_value;
            if (st_d == hss_pkg::ST_CAL && enter) mass_q <= init_q;
            else if (wr_mass && !last_mass) mass_q <= mass_q + 8'h01;
            if (st_d == hss_pkg::ST_CAL && enter) tmr_q <= 16'(hss_pkg::CAL_CYC);
            else if (st_d == hss_pkg::ST_SETTLE && enter) tmr_q <= dwell;
            else if (tmr_q != 16'h0000) tmr_q <= tmr_q - 16'h0001;
        end
    end

    // measurement request pulse and kind
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q  <= 1'b0;
            kind_q <= hss_pkg::KIND_ZERO;
        end else begin
            req_q  <= req_n;
            if (req_n) kind_q <= kind_n;
        end
    end

    // scan memory; no reset so it maps onto ram
    always_ff @(posedge sys_clk) begin
        if (wr_en) buf_mem[wr_q[hss_pkg::BUF_AW-1:0]] <= wr_val;
    end

    // buffer pointers; an abort drops every unsent word at once
    // pointers carry one extra bit so full and empty differ; a scan never
    // exceeds the depth, so no full flag is kept
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (wr_en) wr_q <= wr_q + 1'b1;
            if (abort) rd_q <= wr_q;
            else if (tx_load) rd_q <= rd_q + 1'b1;
        end
    end

    // byte serialiser, least significant byte first
    // one idle cycle between words costs a fifth of the stream rate at most;
    // traded for a load path that never competes with a take
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            txv_q  <= 1'b0;
            txd_q  <= 8'h00;
            sh_q   <= 24'h000000;
            bidx_q <= 2'h0;
        end else if (abort) begin
            txv_q  <= 1'b0;
        end else if (tx_load) begin
            txv_q  <= 1'b1;
            txd_q  <= head_word[7:0];
            sh_q   <= head_word[31:8];
            bidx_q <= 2'h0;
        end else if (tx_take) begin
            txv_q  <= (bidx_q != 2'h3);
            txd_q  <= sh_q[7:0];
            sh_q   <= {8'h00, sh_q[23:8]};
            bidx_q <= bidx_q + 2'h1;
        end
    end

    // outputs straight from flops
    assign s_axi_awready    = aw_rdy_q;
    assign s_axi_wready     = w_rdy_q;
    assign s_axi_bvalid     = bv_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = ar_rdy_q;
    assign s_axi_rvalid     = rv_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    assign meas_req         = req_q;
    assign meas_kind        = kind_q;
    assign meas_mass        = mass_q;
    assign meas_use_mult    = run_mult_q;
    assign meas_noise_floor = run_nf_q;
    assign tx_valid         = txv_q;
    assign tx_data          = txd_q;
endmodule // hss_top

// >>> design/hss_pkg.sv
// constants shared by the histogram scan sequencer
package hss_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 10;
    // register byte offsets
    localparam logic [7:0] CMD_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] POINTS_OFS   = 8'h08;
    localparam logic [7:0] SETTINGS_OFS = 8'h0c;
    localparam logic [7:0] ZERO_OFS     = 8'h10;
    // command word fields
    localparam int CODE_LSB = 0;
    localparam int ARG_LSB  = 8;
    // command codes
    localparam logic [7:0] OP_HIST_TRIG   = 8'h01;
    localparam logic [7:0] OP_HIST_POINTS = 8'h02;
    localparam logic [7:0] OP_INIT_MASS   = 8'h03;
    localparam logic [7:0] OP_FINAL_MASS  = 8'h04;
    localparam logic [7:0] OP_NOISE_FLOOR = 8'h05;
    localparam logic [7:0] OP_MULT_VOLT   = 8'h06;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // measurement kinds
    localparam logic [1:0] KIND_ZERO  = 2'h0;
    localparam logic [1:0] KIND_MASS  = 2'h1;
    localparam logic [1:0] KIND_TOTAL = 2'h2;
    // reset values
    localparam logic [7:0]  INIT_MASS_RST  = 8'h01;
    localparam logic [7:0]  FINAL_MASS_RST = 8'h32;
    localparam logic [2:0]  NF_RST         = 3'h0;
    localparam logic [31:0] ZERO_RST       = 32'h0000_0000;
    // scan buffer: one whole scan of up to 256 masses plus total pressure
    localparam int BUF_AW    = 9;
    localparam int NF_LEVELS = 8;
    // timing
    localparam int CAL_TIME_NS   = 2000;
    localparam int CAL_CYC       = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DWELL_UNIT_NS = 500;
    localparam int DWELL_CYC     = (DWELL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sequencer states, gray along the scan path
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DRAIN  = 3'b001,
        ST_ZERO   = 3'b011,
        ST_CAL    = 3'b010,
        ST_SETTLE = 3'b110,
        ST_MEAS   = 3'b111,
        ST_TOTAL  = 3'b101,
        ST_DONE   = 3'b100
    } hss_state_t;
endpackage

// >>> testbench/hss_host_model.sv
// host side model: measurement front end and serial byte sink
module hss_host_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // measurement requests
    input  wire logic        meas_req,
    input  wire logic [1:0]  meas_kind,
    input  wire logic [7:0]  meas_mass,
    output logic             meas_done,
    output logic [31:0]      meas_value,
    // byte stream and pacing
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    output logic             tx_ready,
    input  wire logic        slow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  wait_q;
    logic [31:0] val_q;
    logic        ph_q;
    // answer after one or nine cycles; a new request replaces an aborted one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 4'h0;
            val_q  <= 32'h0;
            ph_q   <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
            if (meas_req) begin
                wait_q <= slow ? 4'h9 : 4'h1;
                val_q  <= (meas_kind == 2'h0) ? 32'h10 : (meas_kind == 2'h1) ? {24'hff_ffff, meas_mass} : 32'h5000;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
    // value is scrambled outside the done pulse so stale data cannot pass
    assign meas_done  = (wait_q == 4'h1);
    assign meas_value = meas_done ? val_q : ~val_q;
    assign tx_ready   = !slow || ph_q; // slow host stalls every other cycle
endmodule // hss_host_model

// >>> testbench/hss_chk.sv
// concurrent checks on the histogram scan sequencer ports
module hss_chk (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // measurement and stream
    input wire logic        meas_req,
    input wire logic [1:0]  meas_kind,
    input wire logic        meas_use_mult,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_ready
);
    logic [7:0] aw_q;
    // remember the write address so the response can be judged later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= s_axi_awaddr;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_meas_pulse: assert property (meas_req |=> !meas_req) else $error("meas_req longer than one cycle");
    a_total_mult: assert property (meas_req && meas_use_mult |-> meas_kind != hss_pkg::KIND_TOTAL)
        else $error("total measured with multiplier on");
    // a command executing in mid-scan may flush the byte on offer
    a_tx_hold: assert property (tx_valid && !tx_ready |=> (tx_valid && $stable(tx_data)) || $rose(s_axi_bvalid))
        else $error("stream byte dropped before taken");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_write_resp: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == ((aw_q == hss_pkg::CMD_OFS) ?
        hss_pkg::RESP_OKAY : hss_pkg::RESP_SLVERR)) else $error("wrong write response code");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > hss_pkg::ZERO_OFS |=>
        s_axi_rresp == hss_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule // hss_chk
bind hss_top hss_chk chk_i (.*);

// >>> testbench/histogram_scan_sequencer_bench.sv
// self-checking bench for the histogram scan sequencer
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module histogram_scan_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] op; logic [15:0] arg; logic [7:0] adr; logic [31:0] msk; logic [31:0] ex;} hss_row_t;
    localparam logic [31:0] ZV = 32'h10;
    localparam logic [31:0] TV = 32'h5000 - ZV;
    logic        sys_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, meas_req, meas_use_mult;
    logic        meas_done, tx_valid, tx_ready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, meas_kind, rsp;
    logic [31:0] s_axi_rdata, meas_value, rd;
    logic [7:0]  meas_mass, tx_data;
    logic [2:0]  meas_noise_floor;
    logic [7:0]  rxq[$];
    int          bad_count = 0, cmp_count = 0;
    hss_row_t    rows[6] = '{'{hss_pkg::OP_INIT_MASS, 16'd10, hss_pkg::SETTINGS_OFS, 32'hff, 32'h0a},
        '{hss_pkg::OP_FINAL_MASS, 16'd12, hss_pkg::SETTINGS_OFS, 32'hff00, 32'h0c00},
        '{hss_pkg::OP_NOISE_FLOOR, 16'd7, hss_pkg::SETTINGS_OFS, 32'h0e00_0000, 32'h0e00_0000},
        '{hss_pkg::OP_MULT_VOLT, 16'd1, hss_pkg::SETTINGS_OFS, 32'h0100_0000, 32'h0100_0000},
        '{hss_pkg::OP_MULT_VOLT, 16'd0, hss_pkg::SETTINGS_OFS, 32'h0100_0000, 32'h0},
        '{hss_pkg::OP_HIST_POINTS, 16'd0, hss_pkg::POINTS_OFS, 32'h1ff, 32'h3}};
    always #(hss_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
    hss_top DUT (.*);
    hss_host_model host (.*);
    // the host keeps every byte it takes
    always @(posedge sys_clk) begin
        if (rst_n && tx_valid && tx_ready) rxq.push_back(tx_data);
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ready is sampled at the falling edge; it only moves on rising edges
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_h, w_h, b_h;
        b_h = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 100 && !b_h; n++) begin
            @(negedge sys_clk);
            aw_h = s_axi_awvalid && s_axi_awready;
            w_h = s_axi_wvalid && s_axi_wready;
            b_h = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge sys_clk);
            if (aw_h) s_axi_awvalid <= 1'b0;
            if (w_h) s_axi_wvalid <= 1'b0;
            if (b_h) s_axi_bready <= 1'b0;
        end
        if (!b_h) begin bad_count++; conclude(); end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ar_h, r_h;
        r_h = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 100 && !r_h; n++) begin
            @(negedge sys_clk);
            ar_h = s_axi_arvalid && s_axi_arready;
            r_h = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge sys_clk);
            if (ar_h) s_axi_arvalid <= 1'b0;
            if (r_h) s_axi_rready <= 1'b0;
        end
        if (!r_h) begin bad_count++; conclude(); end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
        axi_wr(hss_pkg::CMD_OFS, {8'h00, arg, op});
    endtask
    task automatic wait_bytes(input int n);
        for (int i = 0; i < 30000 && rxq.size() < n; i++) @(posedge sys_clk);
        if (rxq.size() < n) begin bad_count++; conclude(); end
    endtask
    // words arrive least significant byte first
    function automatic logic [31:0] word(input int i);
        return {rxq[4*i+3], rxq[4*i+2], rxq[4*i+1], rxq[4*i]};
    endfunction
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        axi_rd(hss_pkg::SETTINGS_OFS);
        `CHK("settings reset", 32'h0000_3201, rd)
        axi_rd(hss_pkg::ZERO_OFS);
        `CHK("zero reset", 32'h0, rd)
        axi_rd(8'h14);
        `CHK("unmapped read", 34'h2_0000_0000, {rsp, rd})
        axi_wr(hss_pkg::STATUS_OFS, 32'h0000_0301);
        `CHK("read-only write", hss_pkg::RESP_SLVERR, rsp)
        // setting then read back each value, as a careful host does
        foreach (rows[i]) begin
            cmd(rows[i].op, rows[i].arg);
            axi_rd(rows[i].adr);
            `CHK("readback", rows[i].ex, rd & rows[i].msk)
        end
        // single scan over masses 10 to 12, detector chosen beforehand
        cmd(hss_pkg::OP_HIST_TRIG, 16'd1);
        repeat (2) @(negedge sys_clk);
        `CHK("scan noise floor", 3'h7, meas_noise_floor)
        `CHK("scan detector", 1'b0, meas_use_mult)
        wait_bytes(16);
        for (int i = 0; i < 3; i++) `CHK("mass word", {24'hff_ffff, 8'(10 + i)} - ZV, word(i))
        `CHK("total word", TV, word(3))
        axi_rd(hss_pkg::ZERO_OFS);
        `CHK("zero offset", ZV, rd)
        // two scans with the multiplier on and a stalling host
        rxq.delete();
        slow <= 1'b1;
        cmd(hss_pkg::OP_MULT_VOLT, 16'd5);
        cmd(hss_pkg::OP_HIST_TRIG, 16'd2);
        wait_bytes(32);
        for (int s = 0; s < 2; s++) `CHK("multiplier total", 32'h0, word(4 * s + 3))
        `CHK("second scan", {24'hff_ffff, 8'd10} - ZV, word(4))
        // continuous single-mass scans, then a stray command aborts
        rxq.delete();
        slow <= 1'b0;
        cmd(hss_pkg::OP_MULT_VOLT, 16'd0);
        cmd(hss_pkg::OP_INIT_MASS, 16'd12);
        cmd(hss_pkg::OP_HIST_TRIG, 16'd0);
        wait_bytes(24);
        axi_rd(hss_pkg::STATUS_OFS);
        `CHK("continuous flag", 1'b1, rd[5])
        for (int i = 0; i < 6; i++) `CHK("repeat word", (i % 2) ? TV : {24'hff_ffff, 8'd12} - ZV, word(i))
        cmd(8'h7f, 16'd0);
        `CHK("flushed stream", 1'b0, tx_valid)
        rxq.delete();
        repeat (100) @(posedge sys_clk);
        `CHK("bytes after abort", 0, rxq.size())
        axi_rd(hss_pkg::STATUS_OFS);
        `CHK("idle after abort", 3'h0, rd[2:0])
        conclude();
    end
endmodule // histogram_scan_sequencer_bench
